// >>> rtl/seq_pkg.sv
package seq_pkg;

   localparam int          CLK_NS          = 10;
   localparam int          PULSE_PERIOD_NS = 10000;
   localparam int          PULSE_DIV       = PULSE_PERIOD_NS / CLK_NS;
   localparam int          CLEAR_WIDTH_NS  = 10000;
   localparam int          CLEAR_CYCLES    = (CLEAR_WIDTH_NS + CLK_NS - 1) / CLK_NS;
   localparam int          DIV_W           = 16;
   localparam int          CLR_W           = 16;
   localparam logic [DIV_W-1:0] DIV_LAST   = DIV_W'(PULSE_DIV - 1);
   localparam logic [CLR_W-1:0] CLEAR_LOAD = CLR_W'(CLEAR_CYCLES);

   localparam int          POS_W           = 27;
   localparam logic [POS_W-1:0] DECEL_PULSES = 27'h0000008;
   localparam logic [POS_W-1:0] ONE_PULSE    = 27'h0000001;

   // register byte offsets
   localparam logic [7:0]  OFF_MODE   = 8'h00;
   localparam logic [7:0]  OFF_ENV1   = 8'h04;
   localparam logic [7:0]  OFF_TARGET = 8'h08;
   localparam logic [7:0]  OFF_CMD    = 8'h0C;
   localparam logic [7:0]  OFF_STATUS = 8'h10;
   localparam logic [7:0]  OFF_IRQ_ST = 8'h14;
   localparam logic [7:0]  OFF_IRQ_MK = 8'h18;

   // mode register layout
   localparam int          MODE_LSB = 0;
   localparam int          TYPE_LSB = 8;
   localparam logic [31:0] MODE_MASK = 32'h00000FFF;

   // environment register layout
   localparam int          ELM_BIT  = 3;
   localparam int          LCE_BIT  = 10;
   localparam int          AUTO_BIT = 11;
   localparam logic [31:0] ENV_MASK = 32'h00000C08;
   localparam logic [31:0] ENV_RESET = 32'h00000000;

   // status register layout
   localparam int          STS_BUSY    = 0;
   localparam int          STS_NORMAL  = 1;
   localparam int          STS_LIMIT   = 2;
   localparam int          STS_REFUSED = 3;
   localparam int          STS_STATE   = 8;

   // interrupt status and mask layout
   localparam int          IRQ_W     = 3;
   localparam int          IRQ_DONE  = 0;
   localparam int          IRQ_LIMIT = 1;
   localparam int          IRQ_CLEAR = 2;

   localparam logic [7:0]  MODE_LEAVE_POS  = 8'h12;
   localparam logic [7:0]  MODE_LEAVE_NEG  = 8'h1A;
   localparam logic [7:0]  MODE_SEARCH_POS = 8'h15;
   localparam logic [7:0]  MODE_SEARCH_NEG = 8'h1D;
   localparam logic [7:0]  CMD_CONST_A     = 8'h50;
   localparam logic [7:0]  CMD_CONST_B     = 8'h51;

   localparam logic [3:0]  HOMING_BASIC = 4'h0;

   typedef enum logic [4:0] {
      S_IDLE   = 5'h01,
      S_LEAVE  = 5'h02,
      S_SEEK   = 5'h04,
      S_ESCAPE = 5'h08,
      S_WAIT   = 5'h10
   } state_type;

   // homing types that seek the end limit instead of the origin sensor
   function automatic logic uses_limit(input logic [3:0] t);
      return (t == 4'h6) || (t == 4'h7) || (t == 4'h8) || (t == 4'hC);
   endfunction

   // homing types that finish on an encoder zero mark
   function automatic logic uses_ez(input logic [3:0] t);
      return (t == 4'h4) || (t == 4'h5) || (t == 4'h7) || (t == 4'h8) ||
             (t == 4'hA) || (t == 4'hB) || (t == 4'hC);
   endfunction

endpackage

// >>> rtl/pulse_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pulse_ctl_if import seq_pkg::*; ();
   logic             go;
   logic             dir;
   logic             counted;
   logic [POS_W-1:0] count;
   logic             halt;
   logic             slow_halt;
   logic             busy;
   logic             pulse;

   modport ctrl (output go, dir, counted, count, halt, slow_halt, input busy, pulse);
   modport gen  (input go, dir, counted, count, halt, slow_halt, output busy, pulse);
endinterface
`default_nettype wire

// >>> rtl/pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_gen import seq_pkg::*; (
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   pulse_ctl_if.gen   ctl,
   output logic       step_o,
   output logic       dir_o
);

   logic [DIV_W-1:0] div;
   logic [POS_W-1:0] left;
   logic             counted;
   logic             busy;

   wire tick      = busy && (div == DIV_LAST);
   wire last_tick = tick && counted && (left <= ONE_PULSE);

   assign ctl.busy  = busy;
   assign ctl.pulse = step_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy    <= 1'b0;
         div     <= '0;
         left    <= '0;
         counted <= 1'b0;
         step_o  <= 1'b0;
         dir_o   <= 1'b0;
      end else begin
         step_o <= tick;
         if (ctl.go) begin
            busy    <= 1'b1;
            div     <= '0;
            left    <= ctl.count;
            counted <= ctl.counted;
            dir_o   <= ctl.dir;
         end else if (ctl.halt) begin
            busy <= 1'b0;
         end else if (busy) begin
            div <= tick ? '0 : div + 1'b1;
            if (last_tick) begin
               busy <= 1'b0;
            end else if (ctl.slow_halt) begin
               // decelerating stop: a short tail of at most DECEL_PULSES pulses
               counted <= 1'b1;
               if (!counted || left > DECEL_PULSES) begin
                  left <= DECEL_PULSES;
               end
            end else if (tick && counted) begin
               left <= left - ONE_PULSE;
            end
         end
      end
   end

endmodule
`default_nettype wire

// >>> rtl/origin_sequencer.sv
// Contract
// - four-bit homing type selects thirteen procedures
// - codes 12h/1Ah leave origin, plus/minus
// - leave start with origin off: no pulses
// - sample origin each pulse, stop when off
// - codes 15h/1Dh origin search, plus/minus
// - origin seen during search: normal stop
// - origin active at start: escape, then return
// - limit in search: basic return, escape, return
// - escape repeats target-length moves until origin off
// - limit clear enable, immediate stop: clear output (code: only for limits met in origin search)
// - auto clear output at origin return end
// - config bit enables automatic clear output
// - limit stop method: immediate or decelerating
`timescale 1ns/1ps
`default_nettype none
module origin_sequencer import seq_pkg::*; (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        origin_in_i,
   input  wire logic        encoder_zero_in_i,
   input  wire logic        end_limit_in_pos_i,
   input  wire logic        end_limit_in_neg_i,
   output logic             step_o,
   output logic             dir_o,
   output logic             deviation_clear_out_o,
   output logic             irq_o
);

   ////////////////////////////////////////////////////////////////////////////////

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   pulse_ctl_if pc ();

   pulse_gen u_gen (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ctl    (pc.gen),
      .step_o (step_o),
      .dir_o  (dir_o)
   );

   logic [31:0]      mode_reg;
   logic [31:0]      env_reg;
   logic [POS_W-1:0] target_reg;
   logic [IRQ_W-1:0] irq_st;
   logic [IRQ_W-1:0] irq_mask;
   state_type        state;
   logic             busy;
   logic             stop_normal;
   logic             stop_limit;
   logic             refused;
   logic             cur_dir;
   logic             req_dir;
   logic [3:0]       typ;
   logic             searching;
   logic             ez_wait;
   logic             restart;
   logic             then_escape;
   logic             end_limit;
   logic             ez_q;
   logic             go;
   logic             halt;
   logic             slow_halt;
   logic             launch_dir;
   logic             launch_counted;
   logic [POS_W-1:0] launch_count;
   logic             ev_done;
   logic             ev_limit;
   logic             ev_clear;
   logic [CLR_W-1:0] clear_cnt;

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode

   wire        wb_req  = cyc_i && stb_i && !ack_o;
   wire        wb_wr   = wb_req && we_i;
   wire        wr_mode = wb_wr && (adr_i == OFF_MODE);
   wire        wr_env  = wb_wr && (adr_i == OFF_ENV1);
   wire        wr_tgt  = wb_wr && (adr_i == OFF_TARGET);
   wire        wr_cmd  = wb_wr && (adr_i == OFF_CMD) && sel_i[0];
   wire        wr_ist  = wb_wr && (adr_i == OFF_IRQ_ST);
   wire        wr_imk  = wb_wr && (adr_i == OFF_IRQ_MK);

   wire [7:0]  op_mode = mode_reg[MODE_LSB +: 8];
   wire [3:0]  homing_type = mode_reg[TYPE_LSB +: 4];
   wire        elm  = env_reg[ELM_BIT];
   wire        lce  = env_reg[LCE_BIT];
   wire        auto = env_reg[AUTO_BIT];

   wire        mode_leave  = (op_mode == MODE_LEAVE_POS) || (op_mode == MODE_LEAVE_NEG);
   wire        mode_search = (op_mode == MODE_SEARCH_POS) ||
                             (op_mode == MODE_SEARCH_NEG);
   wire        mode_neg    = (op_mode == MODE_LEAVE_NEG) || (op_mode == MODE_SEARCH_NEG);
   wire        const_cmd   = (dat_i[7:0] == CMD_CONST_A) || (dat_i[7:0] == CMD_CONST_B);
   // a high-speed start or a start while busy is dropped and flagged
   wire        start_ok  = wr_cmd && const_cmd && (state == S_IDLE) &&
                           (mode_leave || mode_search);
   wire        start_bad = wr_cmd && !start_ok;

   wire [31:0] status_word = {16'h0000, 3'b000, state, 4'h0,
                              refused, stop_limit, stop_normal, busy};
   wire [31:0] rd_word =
      (adr_i == OFF_MODE)   ? mode_reg :
      (adr_i == OFF_ENV1)   ? env_reg :
      (adr_i == OFF_TARGET) ? {5'h00, target_reg} :
      (adr_i == OFF_STATUS) ? status_word :
      (adr_i == OFF_IRQ_ST) ? {29'h00000000, irq_st} :
      (adr_i == OFF_IRQ_MK) ? {29'h00000000, irq_mask} : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////////
   // sequencing conditions

   wire gen_idle  = !pc.busy && !go;
   wire limit_hit = cur_dir ? end_limit_in_neg_i : end_limit_in_pos_i;
   wire ez_rise   = encoder_zero_in_i && !ez_q;
   wire trig      = uses_limit(typ) ? limit_hit : origin_in_i;
   wire seek_done = (state == S_SEEK) &&
                    (ez_wait ? ez_rise : (trig && !uses_ez(typ)));
   wire seek_arm  = (state == S_SEEK) && !ez_wait && trig && uses_ez(typ);
   wire seek_lim  = (state == S_SEEK) && limit_hit && !uses_limit(typ);
   wire lim_clear = lce && !elm;

   assign pc.go        = go;
   assign pc.halt      = halt;
   assign pc.slow_halt = slow_halt;
   assign pc.dir       = launch_dir;
   assign pc.counted   = launch_counted;
   assign pc.count     = launch_count;

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o      <= 1'b0;
         dat_o      <= 32'h00000000;
         mode_reg   <= 32'h00000000;
         env_reg    <= ENV_RESET;
         target_reg <= ONE_PULSE;
         irq_mask   <= '0;
      end else begin
         ack_o <= wb_req;
         if (wb_req && !we_i) begin
            dat_o <= rd_word;
         end
         if (wr_mode) begin
            mode_reg <= merge(mode_reg, dat_i, sel_i) & MODE_MASK;
         end
         if (wr_env) begin
            env_reg <= merge(env_reg, dat_i, sel_i) & ENV_MASK;
         end
         if (wr_tgt) begin
            target_reg <= POS_W'(merge({5'h00, target_reg}, dat_i, sel_i));
         end
         if (wr_imk) begin
            irq_mask <= dat_i[IRQ_W-1:0];
         end
      end
   end

   // hardware set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_st <= '0;
         irq_o  <= 1'b0;
      end else begin
         irq_st <= (irq_st & ~(wr_ist ? dat_i[IRQ_W-1:0] : {IRQ_W{1'b0}})) |
                   {ev_clear, ev_limit, ev_done};
         irq_o  <= |(irq_st & irq_mask);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clear_cnt             <= '0;
         deviation_clear_out_o <= 1'b0;
         ez_q                  <= 1'b0;
      end else begin
         ez_q <= encoder_zero_in_i;
         if (ev_clear) begin
            clear_cnt             <= CLEAR_LOAD;
            deviation_clear_out_o <= 1'b1;
         end else if (clear_cnt != '0) begin
            clear_cnt             <= clear_cnt - 1'b1;
            deviation_clear_out_o <= (clear_cnt != CLR_W'(1));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state          <= S_IDLE;
         busy           <= 1'b0;
         stop_normal    <= 1'b0;
         stop_limit     <= 1'b0;
         refused        <= 1'b0;
         cur_dir        <= 1'b0;
         req_dir        <= 1'b0;
         typ            <= HOMING_BASIC;
         searching      <= 1'b0;
         ez_wait        <= 1'b0;
         restart        <= 1'b0;
         then_escape    <= 1'b0;
         end_limit      <= 1'b0;
         go             <= 1'b0;
         halt           <= 1'b0;
         slow_halt      <= 1'b0;
         launch_dir     <= 1'b0;
         launch_counted <= 1'b0;
         launch_count   <= '0;
         ev_done        <= 1'b0;
         ev_limit       <= 1'b0;
         ev_clear       <= 1'b0;
      end else begin
         go        <= 1'b0;
         halt      <= 1'b0;
         slow_halt <= 1'b0;
         ev_done   <= 1'b0;
         ev_limit  <= 1'b0;
         ev_clear  <= 1'b0;
         if (start_bad) begin
            refused <= 1'b1;
         end
         unique case (state)
            S_IDLE: begin
               if (start_ok) begin
                  refused     <= 1'b0;
                  stop_normal <= 1'b0;
                  stop_limit  <= 1'b0;
                  end_limit   <= 1'b0;
                  req_dir     <= mode_neg;
                  typ         <= homing_type;
                  ez_wait     <= 1'b0;
                  restart     <= 1'b0;
                  then_escape <= 1'b0;
                  if (mode_leave && !origin_in_i) begin
                     stop_normal <= 1'b1;
                     ev_done     <= 1'b1;
                  end else if (mode_leave) begin
                     busy           <= 1'b1;
                     cur_dir        <= mode_neg;
                     go             <= 1'b1;
                     launch_dir     <= mode_neg;
                     launch_counted <= 1'b0;
                     state          <= S_LEAVE;
                  end else if (origin_in_i) begin
                     // escape runs away from the requested direction
                     busy           <= 1'b1;
                     cur_dir        <= !mode_neg;
                     go             <= 1'b1;
                     launch_dir     <= !mode_neg;
                     launch_counted <= 1'b1;
                     launch_count   <= target_reg;
                     state          <= S_ESCAPE;
                  end else begin
                     busy           <= 1'b1;
                     cur_dir        <= mode_neg;
                     searching      <= 1'b1;
                     go             <= 1'b1;
                     launch_dir     <= mode_neg;
                     launch_counted <= 1'b0;
                     state          <= S_SEEK;
                  end
               end
            end
            S_LEAVE: begin
               if (limit_hit) begin
                  halt      <= !elm;
                  slow_halt <= elm;
                  end_limit <= 1'b1;
                  state     <= S_WAIT;
               end else if (pc.pulse && !origin_in_i) begin
                  halt  <= 1'b1;
                  state <= S_WAIT;
               end
            end
            S_SEEK: begin
               if (seek_done) begin
                  halt     <= 1'b1;
                  ev_clear <= auto;
                  state    <= S_WAIT;
               end else if (seek_arm && uses_limit(typ)) begin
                  // limit-ended zero-mark types (7, 8, C) turn round and hunt the zero mark
                  halt      <= !elm;
                  slow_halt <= elm;
                  ev_clear  <= lim_clear;
                  restart   <= 1'b1;
                  ez_wait   <= 1'b1;
                  cur_dir   <= !cur_dir;
                  state     <= S_WAIT;
               end else if (seek_arm) begin
                  ez_wait <= 1'b1;
               end else if (seek_lim) begin
                  halt      <= !elm;
                  slow_halt <= elm;
                  ev_clear  <= lim_clear;
                  if (searching) begin
                     searching   <= 1'b0;
                     typ         <= HOMING_BASIC;
                     ez_wait     <= 1'b0;
                     restart     <= 1'b1;
                     then_escape <= 1'b1;
                     cur_dir     <= !cur_dir;
                  end else begin
                     end_limit <= 1'b1;
                  end
                  state <= S_WAIT;
               end
            end
            S_ESCAPE: begin
               if (limit_hit) begin
                  halt      <= !elm;
                  slow_halt <= elm;
                  end_limit <= 1'b1;
                  state     <= S_WAIT;
               end else if (gen_idle && origin_in_i) begin
                  go             <= 1'b1;
                  launch_dir     <= cur_dir;
                  launch_counted <= 1'b1;
                  launch_count   <= target_reg;
               end else if (gen_idle) begin
                  typ            <= homing_type;
                  ez_wait        <= 1'b0;
                  searching      <= 1'b0;
                  cur_dir        <= req_dir;
                  go             <= 1'b1;
                  launch_dir     <= req_dir;
                  launch_counted <= 1'b0;
                  state          <= S_SEEK;
               end
            end
            S_WAIT: begin
               if (gen_idle && restart) begin
                  restart        <= 1'b0;
                  go             <= 1'b1;
                  launch_dir     <= cur_dir;
                  launch_counted <= 1'b0;
                  state          <= S_SEEK;
               end else if (gen_idle && then_escape) begin
                  then_escape    <= 1'b0;
                  go             <= 1'b1;
                  launch_dir     <= cur_dir;
                  launch_counted <= 1'b1;
                  launch_count   <= target_reg;
                  state          <= S_ESCAPE;
               end else if (gen_idle) begin
                  busy        <= 1'b0;
                  stop_normal <= !end_limit;
                  stop_limit  <= end_limit;
                  ev_done     <= !end_limit;
                  ev_limit    <= end_limit;
                  state       <= S_IDLE;
               end
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// >>> verif/origin_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none
module seq_props (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        origin_in_i,
   input wire logic        step_o,
   input wire logic        dir_o,
   input wire logic        deviation_clear_out_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0]  mode;
   logic [1:0]  env;
   logic        held;
   logic [10:0] run;
   wire         wr = cyc_i & stb_i & we_i & ack_o;
   wire         lv = (mode == 8'h12) | (mode == 8'h1A);
   wire         go = wr & (adr_i == 8'h0C) & sel_i[0] & (dat_i[7:1] == 7'h28);
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode <= 8'h00;
         env  <= 2'h0;
         held <= 1'b0;
      end else begin
         if (wr & (adr_i == 8'h00) & sel_i[0]) mode <= dat_i[7:0];
         if (wr & (adr_i == 8'h04) & sel_i[1]) env <= dat_i[11:10];
         if (go) held <= lv & ~origin_in_i;
         else if (step_o & lv & ~origin_in_i) held <= 1'b1;
      end
   end
   // one width counter for every clear pulse, whatever fired it
   always_ff @(posedge clk_i) run <= deviation_clear_out_o ? run + 11'h001 : 11'h000;
   ////////////////////////////////////////////////////////////////
   AST_ACK_NEXT: assert property (cyc_i & stb_i & ~ack_o |=> ack_o)
      else $error("access not answered");
   AST_ACK_ONE: assert property (ack_o |=> ~ack_o)
      else $error("ack too long");
   AST_STEP_GAP: assert property (step_o |=> (~step_o) [*8])
      else $error("pulses too close");
   AST_LEAVE_STOP: assert property (held |-> ~step_o)
      else $error("pulse after origin left");
   AST_LEAVE_DIR: assert property (step_o & lv |-> dir_o == mode[3])
      else $error("leave direction wrong");
   AST_CLEAR_LEN: assert property ($fell(deviation_clear_out_o) |-> run == 11'h3E8)
      else $error("clear width wrong");
   AST_CLEAR_OFF: assert property (env == 2'h0 |-> !$rose(deviation_clear_out_o))
      else $error("clear while disabled");
   AST_HOLE_ZERO: assert property (ack_o & ~we_i & (adr_i > 8'h18) |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   cover property (go & lv & ~origin_in_i);
   cover property ($fell(deviation_clear_out_o));
   cover property (step_o & ~lv);
endmodule
bind origin_sequencer seq_props chk_u (.*);
`default_nettype wire

// >>> verif/motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module motor_model (
   input  wire logic              clk_i,
   input  wire logic              load_i,
   input  wire logic signed [7:0] start_i,
   input  wire logic              step_i,
   input  wire logic              dir_i,
   output logic signed      [7:0] pos_o,
   output logic                   origin_o,
   output logic                   limit_pos_o,
   output logic                   limit_neg_o,
   output logic                   zero_o
);
   wire logic signed [7:0] next_pos = step_i ? (dir_i ? pos_o - 8'sh01 : pos_o + 8'sh01) : pos_o;
   always_ff @(posedge clk_i) pos_o <= load_i ? start_i : next_pos;
   // sensors follow the shaft, so they show where this pulse lands
   assign origin_o    = (next_pos >= 8'sh00) && (next_pos <= 8'sh02);
   // limits close in, so the fallback run stays short
   assign limit_pos_o = next_pos >= 8'sh10;
   assign limit_neg_o = next_pos <= -8'sh10;
   assign zero_o      = step_i & (next_pos[1:0] == 2'h0);
endmodule
`default_nettype wire

// >>> verif/tb_origin_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_origin_sequencer;
   import seq_pkg::*;
   logic                   clk_i, rst_i, cyc_i, stb_i, we_i, load;
   logic             [7:0] adr_i;
   logic             [3:0] sel_i;
   logic            [31:0] dat_i, q;
   logic signed      [7:0] start;
   wire logic       [31:0] dat_o;
   wire logic              ack_o, step_o, dir_o, deviation_clear_out_o, irq_o;
   wire logic              origin_in_i, encoder_zero_in_i;
   wire logic              end_limit_in_pos_i, end_limit_in_neg_i;
   wire logic signed [7:0] pos;
   int                     err_total, samples_checked, steps, seed, t, k;
   origin_sequencer dut_u (.*);
   motor_model motor_u (
      .clk_i       (clk_i),
      .load_i      (load),
      .start_i     (start),
      .step_i      (step_o),
      .dir_i       (dir_o),
      .pos_o       (pos),
      .origin_o    (origin_in_i),
      .limit_pos_o (end_limit_in_pos_i),
      .limit_neg_o (end_limit_in_neg_i),
      .zero_o      (encoder_zero_in_i)
   );
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (step_o === 1'b1) steps++;
   ////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: %s got %h", $time, m, got);
      end
   endtask
   // ack is waited for, never assumed; a lost ack ends the run
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 9) begin
         @(posedge clk_i);
         n++;
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
      chk(n < 9, 1, "bus timeout");
      if (n == 9) report_and_stop();
   endtask
   task automatic run(input logic [11:0] md, input logic signed [7:0] p0, input int es,
                      input logic signed [7:0] ep);
      int n;
      start <= p0;
      load  <= 1'b1;
      @(posedge clk_i);
      load  <= 1'b0;
      bus(1'b1, OFF_IRQ_ST, 32'h7);
      bus(1'b1, OFF_MODE, {20'h0, md});
      steps = 0;
      bus(1'b1, OFF_CMD, 32'h50 | 32'($random(seed) & 1));
      n = 0;
      q = 32'h0;
      // the limit fallback run needs about 8000 polls
      while (q[IRQ_DONE] !== 1'b1 && n < 10000) begin
         bus(1'b0, OFF_IRQ_ST, 32'h0);
         n++;
      end
      chk(n < 10000, 1, "motion timeout");
      if (n == 10000) report_and_stop();
      chk(steps, es, "pulse count");
      chk(32'(pos), 32'(ep), "end position");
      bus(1'b0, OFF_STATUS, 32'h0);
      chk({30'h0, q[STS_LIMIT:STS_NORMAL]}, 32'h1, "stop cause");
      $display("move %h done", md);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
      sel_i = 4'hF;
      rst_i = 1'b1;
      load  = 1'b1;
      start = 8'sh08;
      seed  = 30;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(1'b0, OFF_TARGET, 32'h0);
      chk(q, 32'h1, "target reset");
      bus(1'b0, OFF_ENV1, 32'h0);
      chk(q, ENV_RESET, "env reset");
      bus(1'b1, 8'h1C, 32'hFFFFFFFF);
      bus(1'b0, 8'h1C, 32'h0);
      chk(q, 32'h0, "unmapped read");
      bus(1'b1, OFF_MODE, 32'hFFFFFFFF);
      bus(1'b0, OFF_MODE, 32'h0);
      chk(q, MODE_MASK, "mode field");
      bus(1'b1, OFF_MODE, 32'h12);
      bus(1'b1, OFF_CMD, 32'h52);
      bus(1'b0, OFF_STATUS, 32'h0);
      chk({31'h0, q[STS_REFUSED]}, 32'h1, "refused start");
      $display("register test done");
      run(12'h012, 8'sh08, 0, 8'sh08);
      chk({31'h0, irq_o}, 32'h0, "masked irq");
      bus(1'b1, OFF_IRQ_MK, 32'h1);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h1, "irq raised");
      bus(1'b1, OFF_IRQ_ST, 32'h1);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0, "irq cleared");
      $display("irq test done");
      run(12'h012, 8'sh02, 1, 8'sh03);
      run(12'h01A, 8'sh00, 1, -8'sh01);
      k = 1 + ($unsigned($random(seed)) % 4);
      run(12'h015, -8'(k), k, 8'sh00);
      run(12'h01D, 8'(2 + k), k, 8'sh02);
      t = 1 + ($unsigned($random(seed)) % 3);
      bus(1'b1, OFF_TARGET, 32'(t));
      bus(1'b1, OFF_ENV1, 32'h800);
      run(12'h015, 8'sh00, 2 * t, 8'sh00);
      bus(1'b0, OFF_IRQ_ST, 32'h0);
      chk({31'h0, q[IRQ_CLEAR]}, 32'h1, "clear fired");
      // type 4: origin at 0, then the next zero mark at 4
      run(12'h415, -8'sh01, 5, 8'sh04);
      // limit at 16, basic return to 2, escape in chunks of t, return to 0
      bus(1'b1, OFF_ENV1, 32'h400);
      run(12'h015, 8'sh0C, 16 + 2 * t * ((t + 2) / t), 8'sh00);
      bus(1'b0, OFF_IRQ_ST, 32'h0);
      chk({31'h0, q[IRQ_CLEAR]}, 32'h1, "limit clear fired");
      repeat (1100) @(posedge clk_i);
      report_and_stop();
   end
endmodule
`default_nettype wire
